// file: hw/bcs_pkg.sv
// package: boot configuration capture constants and types
package bcs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_SWITCH_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_SWITCH_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_LINK_STATUS_US = 8'h08;
  localparam logic [7:0] ADDR_LINK_STATUS_DS = 8'h0c;
  localparam logic [7:0] ADDR_MODE_INFO      = 8'h10;

  // switch status fields
  localparam int STS_CCLK_DS   = 0;
  localparam int STS_CCLK_US   = 1;
  localparam int STS_SLOW      = 2;
  localparam int STS_REFCLK    = 3;
  localparam int STS_HALT      = 4;
  localparam int STS_MODE_LO   = 5;
  localparam int STS_AUX_N     = 8;
  localparam int STS_VALID     = 9;
  localparam int STS_IN_RESET  = 10;

  // switch control fields
  localparam int CTL_HALT      = 0;
  localparam int CTL_FUND_RST  = 1;
  localparam int CTL_AUX_DIS   = 2;

  // link status slot clock field
  localparam int LSTS_SCLK     = 0;

  // mode info fields
  localparam int MI_EEPROM     = 0;
  localparam int MI_LOW_LAT    = 1;
  localparam int MI_SLOW       = 2;
  localparam int MI_REF125     = 3;
  localparam int MI_CUT_LO     = 8;

  // reset values
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
  localparam logic [2:0]  RST_MODE   = 3'h0;

  // switch mode encodings
  localparam logic [2:0] MODE_NORMAL        = 3'h0;
  localparam logic [2:0] MODE_EEPROM        = 3'h1;
  localparam logic [2:0] MODE_LOW_LAT       = 3'h2;
  localparam logic [2:0] MODE_EEPROM_LOWLAT = 3'h3;

  // timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int BUS_SLOW_HZ   = 100_000;
  localparam int BUS_FAST_HZ   = 400_000;
  localparam logic [7:0] DIV_SLOW = 8'(CLK_HZ / BUS_SLOW_HZ);
  localparam logic [7:0] DIV_FAST = 8'(CLK_HZ / BUS_FAST_HZ);
  localparam logic [7:0] LAT_CUT_NS = 8'h08;

  typedef enum logic [1:0] {
    SEQ_RESET,
    SEQ_LOAD,
    SEQ_HALT,
    SEQ_RUN
  } bcs_seq_t;
endpackage

// file: hw/bcs_sync.sv
// two-flop synchroniser for a group of pin levels
module bcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// file: hw/bcs_top.sv
// boot configuration capture, override and distribution with ahb-lite regs
// How it works
// - capture all straps when reset pin negates
// - straps ignored outside capture; captured copy used
// - eeprom load can write the halt, aux disable and slot clock bits only
// - only halt, aux, common-clock bits overridable
// - status register shows captured strap values
// - downstream slot clock bits reset from strap
// - upstream slot clock bit reset from strap
// - slow strap selects 100k, else 400k
// - refclk select: 0 is 100MHz, 1 125MHz
// - halt strap: stay in reset, bus alive
// - leave halt only when halt bit cleared
// - mode decode: normal, eeprom, low latency
// - low latency modes cut latency 8 ns
// - aux strap low disables aux, clears sticky
// - warm reset reuses previously captured values
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
module bcs_top
  import bcs_pkg::*;
#(
  parameter int DS_PORTS = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                fundamental_reset_in_n,
  input  wire logic                common_clk_downstream_strap,
  input  wire logic                common_clk_upstream_strap,
  input  wire logic                master_bus_slow_strap,
  input  wire logic                refclk_freq_select,
  input  wire logic                reset_halt_request,
  input  wire logic [2:0]          switch_mode_strap,
  input  wire logic                aux_power_disable_n,
  input  wire logic                ee_wr_en,
  input  wire logic [7:0]          ee_addr,
  input  wire logic [31:0]         ee_wdata,
  input  wire logic                ee_load_done,
  input  wire logic                ee_load_error,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  output logic                     device_in_reset,
  output logic                     master_bus_tick,
  output logic                     master_bus_slow,
  output logic                     refclk_is_125,
  output logic                     eeprom_init_mode,
  output logic                     low_latency_mode,
  output logic [7:0]               latency_cut_ns,
  output logic                     aux_power_enable,
  output logic                     sticky_clear,
  output logic                     slot_clk_upstream,
  output logic [DS_PORTS-1:0]      slot_clk_downstream
);
  // synchronised pins
  logic [9:0] pins_s;
  logic       rst_in_n_s;
  logic       ccds_s;
  logic       ccus_s;
  logic       slow_s;
  logic       ref_s;
  logic       halt_s;
  logic [2:0] mode_s;
  logic       aux_n_s;

  bcs_sync #(
    .W(10)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({fundamental_reset_in_n, common_clk_downstream_strap,
           common_clk_upstream_strap, master_bus_slow_strap,
           refclk_freq_select, reset_halt_request, switch_mode_strap,
           aux_power_disable_n}),
    .q   (pins_s)
  );

  assign {rst_in_n_s, ccds_s, ccus_s, slow_s, ref_s, halt_s, mode_s,
          aux_n_s} = pins_s;

  function automatic logic [1:0] mode_decode(input logic [2:0] m);
    case (m)
      MODE_NORMAL:        mode_decode = 2'h0;
      MODE_EEPROM:        mode_decode = 2'h1;
      MODE_LOW_LAT:       mode_decode = 2'h2;
      MODE_EEPROM_LOWLAT: mode_decode = 2'h3;
      default:            mode_decode = 2'h0;  // reserved
    endcase
  endfunction

  // ---------------- bus front end ----------------
  logic        wr_pend_ff;
  logic        nxt_wr_pend;
  logic [7:0]  wr_addr_ff;
  logic [7:0]  nxt_wr_addr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic        hreadyout_ff;
  logic [31:0] rd_word;
  logic        addr_phase;

  assign addr_phase = hsel & hready & htrans[1];

  // ---------------- configuration state ----------------
  bcs_seq_t             seq_ff;
  bcs_seq_t             nxt_seq;
  logic                 rst_in_prev_ff;
  logic                 cap_valid_ff;
  logic                 nxt_cap_valid;
  logic                 cap_ccds_ff;
  logic                 nxt_cap_ccds;
  logic                 cap_ccus_ff;
  logic                 nxt_cap_ccus;
  logic                 cap_slow_ff;
  logic                 nxt_cap_slow;
  logic                 cap_ref_ff;
  logic                 nxt_cap_ref;
  logic                 cap_halt_ff;
  logic                 nxt_cap_halt;
  logic [2:0]           cap_mode_ff;
  logic [2:0]           nxt_cap_mode;
  logic                 cap_aux_n_ff;
  logic                 nxt_cap_aux_n;
  logic                 ctl_halt_ff;
  logic                 nxt_ctl_halt;
  logic                 ctl_aux_dis_ff;
  logic                 nxt_ctl_aux_dis;
  logic                 sclk_us_ff;
  logic                 nxt_sclk_us;
  logic [DS_PORTS-1:0]  sclk_ds_ff;
  logic [DS_PORTS-1:0]  nxt_sclk_ds;
  logic                 sticky_clear_ff;
  logic                 nxt_sticky_clear;
  logic                 in_reset_ff;
  logic [1:0]           strap_dec;
  logic [1:0]           nxt_dec;
  logic [1:0]           dec_ff;
  logic [7:0]           cut_ff;
  logic                 aux_en_ff;
  logic                 wr_en;
  logic [7:0]           wr_addr;
  logic [31:0]          wr_data;

  // bus write in its data phase wins over an eeprom write that cycle
  assign wr_en   = wr_pend_ff | ee_wr_en;
  assign wr_addr = wr_pend_ff ? wr_addr_ff : ee_addr;
  assign wr_data = wr_pend_ff ? hwdata : ee_wdata;
  assign strap_dec = mode_decode(mode_s);
  assign nxt_dec   = mode_decode(nxt_cap_mode);

  always_comb begin
    nxt_seq          = seq_ff;
    nxt_cap_valid    = cap_valid_ff;
    nxt_cap_ccds     = cap_ccds_ff;
    nxt_cap_ccus     = cap_ccus_ff;
    nxt_cap_slow     = cap_slow_ff;
    nxt_cap_ref      = cap_ref_ff;
    nxt_cap_halt     = cap_halt_ff;
    nxt_cap_mode     = cap_mode_ff;
    nxt_cap_aux_n    = cap_aux_n_ff;
    nxt_ctl_halt     = ctl_halt_ff;
    nxt_ctl_aux_dis  = ctl_aux_dis_ff;
    nxt_sclk_us      = sclk_us_ff;
    nxt_sclk_ds      = sclk_ds_ff;
    nxt_sticky_clear = 1'b0;
    // software and eeprom writes
    if (wr_en) begin
      case (wr_addr)
        ADDR_SWITCH_CONTROL: begin
          nxt_ctl_halt = wr_data[CTL_HALT];
          if (seq_ff != SEQ_RUN) begin
            nxt_ctl_aux_dis = wr_data[CTL_AUX_DIS];
          end
        end
        ADDR_LINK_STATUS_US: nxt_sclk_us = wr_data[LSTS_SCLK];
        ADDR_LINK_STATUS_DS: nxt_sclk_ds = wr_data[DS_PORTS-1:0];
        default: begin
        end
      endcase
    end
    case (seq_ff)
      SEQ_RESET: begin
        if (rst_in_n_s && !rst_in_prev_ff) begin
          // pin negation: take a fresh strap sample
          nxt_cap_valid   = 1'b1;
          nxt_cap_ccds    = ccds_s;
          nxt_cap_ccus    = ccus_s;
          nxt_cap_slow    = slow_s;
          nxt_cap_ref     = ref_s;
          nxt_cap_halt    = halt_s;
          nxt_cap_mode    = mode_s;
          nxt_cap_aux_n   = aux_n_s;
          nxt_ctl_halt    = halt_s;
          nxt_ctl_aux_dis = ~aux_n_s;
          nxt_sticky_clear = ~aux_n_s;
          nxt_sclk_us     = ccus_s;
          nxt_sclk_ds     = {DS_PORTS{ccds_s}};
          nxt_seq = strap_dec[0] ? SEQ_LOAD :
                    (halt_s ? SEQ_HALT : SEQ_RUN);
        end
      end
      SEQ_LOAD: begin
        if (ee_load_error) begin
          nxt_ctl_halt = 1'b1;
          nxt_seq      = SEQ_HALT;
        end else if (ee_load_done) begin
          nxt_seq = nxt_ctl_halt ? SEQ_HALT : SEQ_RUN;
        end
      end
      SEQ_HALT: begin
        if (!ctl_halt_ff) begin
          nxt_seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (wr_en && wr_addr == ADDR_SWITCH_CONTROL &&
            wr_data[CTL_FUND_RST]) begin
          // warm reset by register: reuse earlier sample
          nxt_ctl_halt    = cap_halt_ff;
          nxt_ctl_aux_dis = ~cap_aux_n_ff;
          nxt_sticky_clear = ~cap_aux_n_ff;
          nxt_sclk_us     = cap_ccus_ff;
          nxt_sclk_ds     = {DS_PORTS{cap_ccds_ff}};
          nxt_seq = dec_ff[0] ? SEQ_LOAD :
                    (cap_halt_ff ? SEQ_HALT : SEQ_RUN);
        end
      end
      default: nxt_seq = SEQ_RESET;
    endcase
    if (!rst_in_n_s) begin
      nxt_seq = SEQ_RESET;  // pin asserted: straps only read at exit
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_ff          <= SEQ_RESET;
      rst_in_prev_ff  <= 1'b0;
      cap_valid_ff    <= 1'b0;
      cap_ccds_ff     <= 1'b0;
      cap_ccus_ff     <= 1'b0;
      cap_slow_ff     <= 1'b0;
      cap_ref_ff      <= 1'b0;
      cap_halt_ff     <= 1'b0;
      cap_mode_ff     <= RST_MODE;
      cap_aux_n_ff    <= 1'b0;
      ctl_halt_ff     <= 1'b0;
      ctl_aux_dis_ff  <= 1'b0;
      sclk_us_ff      <= 1'b0;
      sclk_ds_ff      <= '0;
      sticky_clear_ff <= 1'b0;
      in_reset_ff     <= 1'b1;
    end else begin
      seq_ff          <= nxt_seq;
      rst_in_prev_ff  <= rst_in_n_s;
      cap_valid_ff    <= nxt_cap_valid;
      cap_ccds_ff     <= nxt_cap_ccds;
      cap_ccus_ff     <= nxt_cap_ccus;
      cap_slow_ff     <= nxt_cap_slow;
      cap_ref_ff      <= nxt_cap_ref;
      cap_halt_ff     <= nxt_cap_halt;
      cap_mode_ff     <= nxt_cap_mode;
      cap_aux_n_ff    <= nxt_cap_aux_n;
      ctl_halt_ff     <= nxt_ctl_halt;
      ctl_aux_dis_ff  <= nxt_ctl_aux_dis;
      sclk_us_ff      <= nxt_sclk_us;
      sclk_ds_ff      <= nxt_sclk_ds;
      sticky_clear_ff <= nxt_sticky_clear;
      in_reset_ff     <= (nxt_seq != SEQ_RUN);
    end
  end

  // ---------------- master bus rate divider ----------------
  logic [7:0] div_cnt_ff;
  logic [7:0] nxt_div_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  // bus stays clocked while halted; stopped only under the reset pin
  always_comb begin
    nxt_div_cnt = div_cnt_ff;
    nxt_tick    = 1'b0;
    if (seq_ff == SEQ_RESET) begin
      nxt_div_cnt = 8'h00;
    end else if (div_cnt_ff == 8'h00) begin
      nxt_tick    = 1'b1;
      nxt_div_cnt = (cap_slow_ff ? DIV_SLOW : DIV_FAST) - 8'h01;
    end else begin
      nxt_div_cnt = div_cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= 8'h00;
      tick_ff    <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      tick_ff    <= nxt_tick;
    end
  end

  // ---------------- register read and ahb-lite slave ----------------
  // reads see this cycle's writes through the next-value nets
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_SWITCH_STATUS: begin
        rd_word[STS_CCLK_DS]  = nxt_cap_ccds;
        rd_word[STS_CCLK_US]  = nxt_cap_ccus;
        rd_word[STS_SLOW]     = nxt_cap_slow;
        rd_word[STS_REFCLK]   = nxt_cap_ref;
        rd_word[STS_HALT]     = nxt_cap_halt;
        rd_word[STS_MODE_LO+:3] = nxt_cap_mode;
        rd_word[STS_AUX_N]    = nxt_cap_aux_n;
        rd_word[STS_VALID]    = nxt_cap_valid;
        rd_word[STS_IN_RESET] = (nxt_seq != SEQ_RUN);
      end
      ADDR_SWITCH_CONTROL: begin
        rd_word[CTL_HALT]    = nxt_ctl_halt;
        rd_word[CTL_AUX_DIS] = nxt_ctl_aux_dis;
      end
      ADDR_LINK_STATUS_US: rd_word[LSTS_SCLK] = nxt_sclk_us;
      ADDR_LINK_STATUS_DS: rd_word[DS_PORTS-1:0] = nxt_sclk_ds;
      ADDR_MODE_INFO: begin
        rd_word[MI_EEPROM]  = nxt_dec[0];
        rd_word[MI_LOW_LAT] = nxt_dec[1];
        rd_word[MI_SLOW]    = nxt_cap_slow;
        rd_word[MI_REF125]  = nxt_cap_ref;
        rd_word[MI_CUT_LO+:8] = nxt_dec[1] ? LAT_CUT_NS : 8'h00;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_wr_pend = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_hrdata  = hrdata_ff;
    if (addr_phase) begin
      nxt_wr_pend = hwrite && (hsize == 3'h2) && (haddr[1:0] == 2'h0);
      nxt_wr_addr = haddr[7:0];
      if (!hwrite) begin
        nxt_hrdata = (haddr[31:8] == 24'h00_0000) ? rd_word : RST_RDATA;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hrdata_ff    <= RST_RDATA;
      hreadyout_ff <= 1'b0;
    end else begin
      wr_pend_ff   <= nxt_wr_pend && (haddr[31:8] == 24'h00_0000);
      wr_addr_ff   <= nxt_wr_addr;
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
    end
  end

  // decoded outputs registered so each pin leaves a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_ff    <= 2'h0;
      cut_ff    <= 8'h00;
      aux_en_ff <= 1'b1;
    end else begin
      dec_ff    <= nxt_dec;
      cut_ff    <= nxt_dec[1] ? LAT_CUT_NS : 8'h00;
      aux_en_ff <= ~nxt_ctl_aux_dis;
    end
  end

  // ---------------- outputs ----------------
  assign hreadyout           = hreadyout_ff;
  assign hrdata              = hrdata_ff;
  assign hresp               = 1'b0;
  assign device_in_reset     = in_reset_ff;
  assign master_bus_tick     = tick_ff;
  assign master_bus_slow     = cap_slow_ff;
  assign refclk_is_125       = cap_ref_ff;
  assign eeprom_init_mode    = dec_ff[0];
  assign low_latency_mode    = dec_ff[1];
  assign latency_cut_ns      = cut_ff;
  assign aux_power_enable    = aux_en_ff;
  assign sticky_clear        = sticky_clear_ff;
  assign slot_clk_upstream   = sclk_us_ff;
  assign slot_clk_downstream = sclk_ds_ff;
endmodule

// file: bench/bcs_top_assertions.sv
// checker: capture, decode and tick assertions on bcs_top ports
module bcs_top_checker
  import bcs_pkg::*;
#(
  parameter int DS_PORTS = 4
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                fundamental_reset_in_n,
  input wire logic                common_clk_downstream_strap,
  input wire logic                common_clk_upstream_strap,
  input wire logic                master_bus_slow_strap,
  input wire logic                refclk_freq_select,
  input wire logic                reset_halt_request,
  input wire logic [2:0]          switch_mode_strap,
  input wire logic                aux_power_disable_n,
  input wire logic                device_in_reset,
  input wire logic                master_bus_tick,
  input wire logic                master_bus_slow,
  input wire logic                refclk_is_125,
  input wire logic                eeprom_init_mode,
  input wire logic                low_latency_mode,
  input wire logic [7:0]          latency_cut_ns,
  input wire logic                aux_power_enable,
  input wire logic                sticky_clear,
  input wire logic                slot_clk_upstream,
  input wire logic [DS_PORTS-1:0] slot_clk_downstream
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] since_ff, nxt_since;
  logic [7:0] gap_ff, nxt_gap;
  logic       have_ff, nxt_have, dir_q_ff, nxt_dir_q;

  // cycles since pin high; tick gap valid between two ticks since pin high or the last rise of device_in_reset
  always_comb begin
    nxt_since = since_ff;
    if (!fundamental_reset_in_n) nxt_since = 4'h0;
    else if (since_ff != 4'hf) nxt_since = since_ff + 4'h1;
    nxt_gap = master_bus_tick ? 8'h00 : gap_ff + 8'h01;
    nxt_have = (have_ff | master_bus_tick) & fundamental_reset_in_n &
               ~(device_in_reset & ~dir_q_ff);
    nxt_dir_q = device_in_reset;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_ff <= 4'h0;
      gap_ff   <= 8'h00;
      have_ff  <= 1'b0;
      dir_q_ff <= 1'b1;
    end else begin
      since_ff <= nxt_since;
      gap_ff   <= nxt_gap;
      have_ff  <= nxt_have;
      dir_q_ff <= nxt_dir_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pin_rise;
    $rose(fundamental_reset_in_n);
  endsequence
  sequence s_settle;
    ##6 1'b1;
  endsequence

  chk_slow_capture: assert property (
    s_pin_rise |-> s_settle ##0
      master_bus_slow == $past(master_bus_slow_strap, 6))
    else $error("slow bus mode not taken from strap");
  chk_ref_capture: assert property (
    s_pin_rise |-> s_settle ##0
      refclk_is_125 == $past(refclk_freq_select, 6))
    else $error("refclk select not taken from strap");
  chk_mode_decode: assert property (
    s_pin_rise |-> s_settle ##0 {low_latency_mode, eeprom_init_mode} ==
      ($past(switch_mode_strap, 6) > 3'h3 ? 2'h0 :
       $past(switch_mode_strap[1:0], 6)))
    else $error("switch mode decoded wrongly");
  chk_latency_cut: assert property (
    low_latency_mode |-> ##[0:2] latency_cut_ns == LAT_CUT_NS)
    else $error("latency cut missing in low latency mode");
  chk_halt_holds: assert property (
    s_pin_rise ##0 reset_halt_request |-> ##3 device_in_reset [*8])
    else $error("halt strap did not hold reset");
  chk_sticky_pulse: assert property (
    s_pin_rise ##0 !aux_power_disable_n |-> ##[1:8] sticky_clear)
    else $error("sticky clear missing with aux strap low");
  chk_sticky_single: assert property (
    sticky_clear |=> !sticky_clear)
    else $error("sticky clear longer than one cycle");
  chk_aux_capture: assert property (
    s_pin_rise |-> s_settle ##0
      aux_power_enable == $past(aux_power_disable_n, 6))
    else $error("aux power enable not taken from strap");
  chk_slot_capture: assert property (
    s_pin_rise |-> s_settle ##0
      slot_clk_downstream == {DS_PORTS{$past(common_clk_downstream_strap,
      6)}} && slot_clk_upstream == $past(common_clk_upstream_strap, 6))
    else $error("slot clock bits not reset from straps");
  chk_tick_period: assert property (
    master_bus_tick && have_ff |->
      gap_ff == (master_bus_slow ? 8'h63 : 8'h18))
    else $error("master bus tick spacing wrong");
  chk_straps_ignored: assert property (
    $changed(master_bus_slow) || $changed(refclk_is_125) ||
    $changed(low_latency_mode) || $changed(eeprom_init_mode)
      |-> since_ff <= 4'h6)
    else $error("captured value changed outside capture");
endmodule

// file: bench/bcs_board.sv
// board model: strap pins and reset pin source
module bcs_board (
  input  wire logic       clk,
  input  wire logic       hold_low,
  input  wire logic [8:0] strap_req,
  output logic            pin_n,
  output logic [8:0]      straps
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pin_n = 1'b0;
    straps = 9'h000;
  end
  always @(posedge clk) begin
    pin_n <= !hold_low;
    straps <= strap_req;
    if (strap_req[7]) straps[7:5] <= 3'h0;
    else if (strap_req[6]) straps[1:0] <= 2'h3;
  end
endmodule

// file: bench/bcs_top_bench.sv
// testbench: strap capture, overrides, halt and warm reset of bcs_top
module bcs_top_bench
  import bcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, hold_low, pin_n, sticky_seen;
  logic [8:0]  strap_req, straps, s;
  logic [1:0]  mm;
  logic        hsel, hwrite, hready, hreadyout, hresp;
  logic        ee_wr_en, ee_load_done, ee_load_error;
  logic [7:0]  ee_addr, latency_cut_ns;
  logic [31:0] haddr, hwdata, hrdata, ee_wdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        device_in_reset, master_bus_tick, master_bus_slow;
  logic        refclk_is_125, eeprom_init_mode, low_latency_mode;
  logic        aux_power_enable, sticky_clear, slot_clk_upstream;
  logic [3:0]  slot_clk_downstream;
  int          err_total, n_compared, cyc;

  assign hready = hreadyout;
  always #50 clk = ~clk;

  bcs_board board (.clk(clk), .hold_low(hold_low), .strap_req(strap_req),
    .pin_n(pin_n), .straps(straps));

  bcs_top #(.DS_PORTS(4)) DUT (.clk(clk), .rst(rst),
    .fundamental_reset_in_n(pin_n),
    .common_clk_downstream_strap(straps[0]),
    .common_clk_upstream_strap(straps[1]),
    .master_bus_slow_strap(straps[2]), .refclk_freq_select(straps[3]),
    .reset_halt_request(straps[4]), .switch_mode_strap(straps[7:5]),
    .aux_power_disable_n(straps[8]), .ee_wr_en(ee_wr_en),
    .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_load_done(ee_load_done),
    .ee_load_error(ee_load_error), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .device_in_reset(device_in_reset),
    .master_bus_tick(master_bus_tick), .master_bus_slow(master_bus_slow),
    .refclk_is_125(refclk_is_125), .eeprom_init_mode(eeprom_init_mode),
    .low_latency_mode(low_latency_mode), .latency_cut_ns(latency_cut_ns),
    .aux_power_enable(aux_power_enable), .sticky_clear(sticky_clear),
    .slot_clk_upstream(slot_clk_upstream),
    .slot_clk_downstream(slot_clk_downstream));

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single-word transfer; read data kept in rd
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(rd, e);
  endtask

  task automatic ee_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ee_wr_en <= 1'b1;
    ee_addr <= a;
    ee_wdata <= d;
    @(posedge clk);
    ee_wr_en <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic ld(input logic done, input logic bad);
    @(posedge clk);
    ee_load_done <= done;
    ee_load_error <= bad;
    @(posedge clk);
    ee_load_done <= 1'b0;
    ee_load_error <= 1'b0;
  endtask

  task automatic pin_cycle(input logic [8:0] v);
    hold_low <= 1'b1;
    repeat (6) @(posedge clk);
    strap_req <= v;
    @(posedge clk);
    hold_low <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    do @(posedge clk); while (master_bus_tick !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (master_bus_tick !== 1'b1);
    check(32'(n), 32'(exp));
  endtask

  always @(posedge clk) begin
    if (pin_n === 1'b0) sticky_seen <= 1'b0;
    else if (sticky_clear === 1'b1) sticky_seen <= 1'b1;
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict;
    end
  end

  initial begin
    clk = 1'b0; rst = 1'b1; hold_low = 1'b1; strap_req = 9'h000;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; ee_wr_en = 1'b0; ee_addr = 8'h00;
    ee_wdata = 32'h0; ee_load_done = 1'b0; ee_load_error = 1'b0;
    err_total = 0; n_compared = 0; cyc = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_SWITCH_STATUS, 32'h0000_0400);
    for (int m = 0; m < 4; m++) begin
      mm = 2'(m);
      s = {mm[1], 1'b0, mm, ~mm[0], mm[1], mm[0], |mm, mm[1]};
      pin_cycle(s);
      rd_chk(ADDR_SWITCH_STATUS, {21'h0, 2'h3, s});
      rd_chk(ADDR_SWITCH_CONTROL, {29'h0, ~s[8], 1'b0, s[4]});
      rd_chk(ADDR_MODE_INFO, {16'h0, mm[1] ? LAT_CUT_NS : 8'h00, 4'h0,
        s[3], s[2], mm});
      check(32'({master_bus_slow, refclk_is_125, eeprom_init_mode,
        low_latency_mode, latency_cut_ns, aux_power_enable,
        slot_clk_upstream, slot_clk_downstream, device_in_reset}),
        32'({s[2], s[3], mm[0], mm[1], mm[1] ? LAT_CUT_NS : 8'h00, s[8],
        s[1], {4{s[0]}}, 1'b1}));
      check(32'(sticky_seen), 32'(!s[8]));
      tick_gap(s[2] ? 100 : 25);
      if (mm[0]) begin
        ee_wr(ADDR_LINK_STATUS_US, {31'h0, ~s[1]});
        check(32'(slot_clk_upstream), 32'(!s[1]));
        ld(m == 1, m == 3);
      end
      repeat (20) @(posedge clk);
      check(32'(device_in_reset), 32'(m != 1));
      bus(ADDR_SWITCH_CONTROL, 1'b1, 32'h0);
      bus(ADDR_SWITCH_STATUS, 1'b1, 32'hffff_ffff);
      bus(ADDR_MODE_INFO, 1'b1, 32'hffff_ffff);
      repeat (3) @(posedge clk);
      check(32'({device_in_reset, aux_power_enable}),
        32'({1'b0, (m != 1) | s[8]}));
      rd_chk(ADDR_SWITCH_STATUS, {21'h0, 2'h1, s});
      check(32'(master_bus_slow), 32'(s[2]));
    end
    bus(8'h20, 1'b1, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0);
    strap_req <= 9'h04a;
    repeat (30) @(posedge clk);
    rd_chk(ADDR_SWITCH_STATUS, {21'h0, 2'h1, s});
    bus(ADDR_LINK_STATUS_DS, 1'b1, 32'h0000_000a);
    @(posedge clk);
    check(32'(slot_clk_downstream), 32'h0000_000a);
    bus(ADDR_SWITCH_CONTROL, 1'b1, 32'h0000_0002);
    repeat (10) @(posedge clk);
    ld(1'b1, 1'b0);
    repeat (20) @(posedge clk);
    check(32'({device_in_reset, slot_clk_downstream}),
      32'({1'b0, {4{s[0]}}}));
    rd_chk(ADDR_SWITCH_STATUS, {21'h0, 2'h1, s});
    give_verdict;
  end
endmodule

bind bcs_top bcs_top_checker #(.DS_PORTS(DS_PORTS)) u_chk (.clk, .rst,
  .fundamental_reset_in_n, .common_clk_downstream_strap,
  .common_clk_upstream_strap, .master_bus_slow_strap, .refclk_freq_select,
  .reset_halt_request, .switch_mode_strap, .aux_power_disable_n,
  .device_in_reset, .master_bus_tick, .master_bus_slow, .refclk_is_125,
  .eeprom_init_mode, .low_latency_mode, .latency_cut_ns, .aux_power_enable,
  .sticky_clear, .slot_clk_upstream, .slot_clk_downstream);
